// file: dogzfm_pkg.sv
/*
  Shared constants for the converter output control block: status register map,
  gain level encodings, run thresholds and the run-bit release delay.
  Assumes every user imports the whole package.
*/
package dogzfm_pkg;

  localparam logic [7:0] FULLSCALE_STATUS_OFFSET = 8'h06;
  localparam int         FS_LEFT_BIT             = 0;
  localparam int         FS_RIGHT_BIT            = 1;
  localparam logic [7:0] FULLSCALE_STATUS_RESET  = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE     = 8'h00;

  localparam logic [1:0] GAIN_NOMINAL = 2'h0;
  localparam logic [1:0] GAIN_HIGH    = 2'h1;
  localparam logic [1:0] GAIN_REDUCED = 2'h2;

  localparam logic [2:0] GC_NOMINAL_A = 3'h0;
  localparam logic [2:0] GC_NOMINAL_B = 3'h1;
  localparam logic [2:0] GC_HIGH_A    = 3'h4;
  localparam logic [2:0] GC_HIGH_B    = 3'h5;

  localparam int ZERO_RUN_FRAMES    = 8192;
  localparam int FULLSCALE_RUN_BITS = 2048;
  localparam int RUN_RELEASE_FRAMES = 4;

  localparam logic [2:0] TRANSITION_TIME_RESET = 3'h0;

  typedef enum logic [0:0] {
    FS_NORMAL,
    FS_MUTED
  } dogzfm_fs_state_t;

endpackage

// file: dogzfm_route_if.sv
/*
  Carrier between the top and the channel router: inputs, selects, outputs.
  Assumes the top drives the user side and the router the router side.
*/
`timescale 1ns/100ps
interface dogzfm_route_if #(parameter int W = 32);
  logic signed [W-1:0] in_l;
  logic signed [W-1:0] in_r;
  logic signed [W-1:0] out_l;
  logic signed [W-1:0] out_r;
  logic                swap;
  logic                mono;
  logic                inv_l;
  logic                inv_r;
  modport router (input in_l, in_r, swap, mono, inv_l, inv_r, output out_l, out_r);
  modport user   (output in_l, in_r, swap, mono, inv_l, inv_r, input out_l, out_r);
endinterface

// file: dogzfm_run_counter.sv
/*
  Run-length detector: counts qualifying ticks while a condition holds,
  restarts on a break, flags once the run reaches the threshold.
  Assumes tick is a one-cycle enable in the single clock domain.
*/
`timescale 1ns/100ps
module dogzfm_run_counter
  import dogzfm_pkg::*;
#(
  parameter int THRESHOLD = 2048,
  parameter int CW        = $clog2(THRESHOLD + 1)
)
(
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic tick,
  input  wire logic hold,
  output logic      hit
);

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;

  localparam logic [CW-1:0] LIMIT = CW'(THRESHOLD);

  always_comb
  begin
    count_next = count_reg;
    if (tick)
    begin
      if (!hold)
        count_next = '0;
      else if (count_reg != LIMIT)
        count_next = count_reg + CW'(1);
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

  assign hit = (count_reg == LIMIT);

endmodule

// file: dogzfm_router.sv
/*
  Channel router for sample words: swap, mono duplication, sign inversion.
  Assumes pin-control straight routing is applied by the caller through the selects.
*/
`timescale 1ns/100ps
module dogzfm_router
  import dogzfm_pkg::*;
#(
  parameter int W = 32
)
(
  dogzfm_route_if.router rt
);

  localparam logic signed [W-1:0] MOST_NEG = {1'b1, {(W-1){1'b0}}};
  localparam logic signed [W-1:0] MOST_POS = {1'b0, {(W-1){1'b1}}};

  logic signed [W-1:0] sel_l;
  logic signed [W-1:0] sel_r;

  // Saturating negate, the most negative code has no positive twin
  function automatic logic signed [W-1:0] negate(input logic signed [W-1:0] v);
    negate = (v == MOST_NEG) ? MOST_POS : -v;
  endfunction

  always_comb
  begin
    if (rt.mono)
    begin
      sel_l = rt.swap ? rt.in_r : rt.in_l;
      sel_r = sel_l;
    end
    else
    begin
      sel_l = rt.swap ? rt.in_r : rt.in_l;
      sel_r = rt.swap ? rt.in_l : rt.in_r;
    end
    rt.out_l = rt.inv_l ? negate(sel_l) : sel_l;
    rt.out_r = rt.inv_r ? negate(sel_r) : sel_r;
  end

endmodule

// file: dogzfm_top.sv
/*
  Output-side control of a two-channel converter: gain decode, zero flags,
  channel routing and inversion, one-bit stream full-scale detection and mute.
  Assumes sample_tick marks one frame-clock period and stream_tick one stream
  bit, both one-cycle pulses synchronous to clock; reset follows power-down.
*/
`timescale 1ns/100ps
// Notes on behaviour
// - Three-bit gain code picks nominal, high or reduced output level.
// - Pin control: gain pin picks nominal or high, sample mode only.
// - Each channel flags zero after 8192 consecutive zero frames.
// - Polarity bit 0 drives detection high, 1 drives it low.
// - Normal polarity flag clears at once on any nonzero sample.
// - After run bit set, flags release one clock after the fourth sample tick, within 3 to 4 sample periods.
// - Combined bit asserts both flags only when both channels are zero.
// - Detect enable 0 disables detection, flags held inactive.
// - Stream bypass path also disables detection, flags inactive.
// - Register control: swap exchanges channels, mono duplicates one input.
// - Register control: per-channel invert bits negate outputs after selection.
// - Pin control: straight routing, right invert pin negates right only.
// - Stream mode: 2048 repeats of the previous bit (2049 equal bits) set channel full-scale flag, read at 06H.
// - Mute enable 1: detection mutes, soft or rapid per bypass select.
// - Transition time and bypass select govern both mute and return.
// - Mute enable 0: full-scale detection never mutes.
// - Recovery mode 0: mute leaves automatically on normal signal.
// - Recovery mode 1, request 0: stays muted despite normal signal.
// - Recovery mode 1: unmute on normal signal and request, request self-clears.
// - Run bit 1 moves the device from reset hold into operation; here it only ends the hold of both zero flags active.
module dogzfm_top
  import dogzfm_pkg::*;
#(
  parameter int W                = 32,
  parameter int ZERO_FRAMES      = ZERO_RUN_FRAMES,
  parameter int FULLSCALE_BITS   = FULLSCALE_RUN_BITS,
  parameter int RELEASE_FRAMES   = RUN_RELEASE_FRAMES
)
(
  input  wire logic          clock,
  input  wire logic          reset,
  input  wire logic          soft_run,
  input  wire logic          pin_control,
  input  wire logic          stream_mode,
  input  wire logic          stream_bypass_select,
  input  wire logic [2:0]    gain_code,
  input  wire logic          gain_pin,
  input  wire logic          zero_flag_polarity,
  input  wire logic          zero_flag_combined,
  input  wire logic          zero_detect_enable,
  input  wire logic          channel_swap,
  input  wire logic          mono,
  input  wire logic          left_invert,
  input  wire logic          right_invert,
  input  wire logic          right_invert_pin,
  input  wire logic          fullscale_mute_enable,
  input  wire logic          fullscale_recovery_mode,
  input  wire logic          recovery_request_write,
  input  wire logic          recovery_request_wdata,
  input  wire logic [2:0]    transition_time_sel,
  input  wire logic          sample_tick,
  input  wire logic [W-1:0]  left_sample,
  input  wire logic [W-1:0]  right_sample,
  input  wire logic          stream_tick,
  input  wire logic          left_bit,
  input  wire logic          right_bit,
  input  wire logic [7:0]    reg_addr,
  output logic [7:0]         reg_rdata,
  output logic [1:0]         gain_level,
  output logic               left_zero_flag,
  output logic               right_zero_flag,
  output logic [W-1:0]       left_out,
  output logic [W-1:0]       right_out,
  output logic               sample_out_valid,
  output logic               left_bit_out,
  output logic               right_bit_out,
  output logic               stream_out_valid,
  output logic               fullscale_mute,
  output logic               fullscale_mute_rapid,
  output logic [2:0]         mute_transition_sel,
  output logic               fullscale_recovery_request
);

  localparam int RCW = $clog2(RELEASE_FRAMES + 1);
  localparam logic [RCW-1:0] RELEASE_LIMIT = RCW'(RELEASE_FRAMES);

  // Route carrier and router
  dogzfm_route_if #(.W(W)) route ();

  logic sel_swap;
  logic sel_mono;
  logic sel_inv_l;
  logic sel_inv_r;

  always_comb
  begin
    if (pin_control)
    begin
      sel_swap  = 1'b0;
      sel_mono  = 1'b0;
      sel_inv_l = 1'b0;
      sel_inv_r = right_invert_pin;
    end
    else
    begin
      sel_swap  = channel_swap;
      sel_mono  = mono;
      sel_inv_l = left_invert;
      sel_inv_r = right_invert;
    end
  end

  assign route.in_l  = left_sample;
  assign route.in_r  = right_sample;
  assign route.swap  = sel_swap;
  assign route.mono  = sel_mono;
  assign route.inv_l = sel_inv_l;
  assign route.inv_r = sel_inv_r;

  dogzfm_router #(.W(W)) u_router (
    .rt (route.router)
  );

  // Stream bits follow the same selection; inversion is a bit flip
  logic sbit_l;
  logic sbit_r;

  always_comb
  begin
    sbit_l = sel_swap ? right_bit : left_bit;
    sbit_r = sel_mono ? sbit_l : (sel_swap ? left_bit : right_bit);
    sbit_l = sbit_l ^ sel_inv_l;
    sbit_r = sbit_r ^ sel_inv_r;
  end

  // Zero detection run counters
  logic zero_hit_l;
  logic zero_hit_r;

  dogzfm_run_counter #(.THRESHOLD(ZERO_FRAMES)) u_zero_l (
    .clock (clock),
    .reset (reset),
    .tick  (sample_tick),
    .hold  (left_sample == '0),
    .hit   (zero_hit_l)
  );

  dogzfm_run_counter #(.THRESHOLD(ZERO_FRAMES)) u_zero_r (
    .clock (clock),
    .reset (reset),
    .tick  (sample_tick),
    .hold  (right_sample == '0),
    .hit   (zero_hit_r)
  );

  // Full-scale run counters, run is a repeat of the previous bit
  logic prev_bit_l_reg;
  logic prev_bit_l_next;
  logic prev_bit_r_reg;
  logic prev_bit_r_next;
  logic fs_hit_l;
  logic fs_hit_r;
  logic fs_tick;

  assign fs_tick = stream_tick & stream_mode;

  dogzfm_run_counter #(.THRESHOLD(FULLSCALE_BITS)) u_fs_l (
    .clock (clock),
    .reset (reset | ~stream_mode),
    .tick  (fs_tick),
    .hold  (left_bit == prev_bit_l_reg),
    .hit   (fs_hit_l)
  );

  dogzfm_run_counter #(.THRESHOLD(FULLSCALE_BITS)) u_fs_r (
    .clock (clock),
    .reset (reset | ~stream_mode),
    .tick  (fs_tick),
    .hold  (right_bit == prev_bit_r_reg),
    .hit   (fs_hit_r)
  );

  always_comb
  begin
    prev_bit_l_next = prev_bit_l_reg;
    prev_bit_r_next = prev_bit_r_reg;
    if (fs_tick)
    begin
      prev_bit_l_next = left_bit;
      prev_bit_r_next = right_bit;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      prev_bit_l_reg <= 1'b0;
      prev_bit_r_reg <= 1'b0;
    end
    else
    begin
      prev_bit_l_reg <= prev_bit_l_next;
      prev_bit_r_reg <= prev_bit_r_next;
    end
  end

  // Run bit release: flags stay asserted a few frames after run goes high
  logic [RCW-1:0] release_reg;
  logic [RCW-1:0] release_next;
  logic           running;

  always_comb
  begin
    release_next = release_reg;
    if (!soft_run)
      release_next = '0;
    else if (sample_tick && release_reg != RELEASE_LIMIT)
      release_next = release_reg + RCW'(1);
  end

  assign running = soft_run && (release_reg == RELEASE_LIMIT);

  // Zero flag computation
  logic detect_off;
  logic det_l;
  logic det_r;
  logic zl_next;
  logic zr_next;

  always_comb
  begin
    detect_off = !zero_detect_enable || (stream_mode && stream_bypass_select);
    if (zero_flag_combined)
    begin
      det_l = zero_hit_l & zero_hit_r;
      det_r = det_l;
    end
    else
    begin
      det_l = zero_hit_l;
      det_r = zero_hit_r;
    end
    // A nonzero sample breaks the run in the same cycle it arrives
    if (sample_tick && left_sample != '0)
      det_l = 1'b0;
    if (sample_tick && right_sample != '0)
      det_r = 1'b0;
    if (sample_tick && zero_flag_combined && (left_sample != '0 || right_sample != '0))
    begin
      det_l = 1'b0;
      det_r = 1'b0;
    end
    if (detect_off)
    begin
      det_l = 1'b0;
      det_r = 1'b0;
    end
    else if (!running)
    begin
      det_l = 1'b1;
      det_r = 1'b1;
    end
    zl_next = det_l ^ zero_flag_polarity;
    zr_next = det_r ^ zero_flag_polarity;
  end

  // Gain decode
  logic [1:0] gain_next;

  always_comb
  begin
    if (pin_control && !stream_mode)
      gain_next = gain_pin ? GAIN_HIGH : GAIN_NOMINAL;
    else if (stream_mode && stream_bypass_select)
      gain_next = GAIN_REDUCED;
    else if (stream_mode)
    begin
      case (gain_code)
        GC_NOMINAL_A: gain_next = GAIN_NOMINAL;
        GC_HIGH_A:    gain_next = GAIN_HIGH;
        default:      gain_next = GAIN_REDUCED;
      endcase
    end
    else
    begin
      case (gain_code)
        GC_NOMINAL_A, GC_NOMINAL_B: gain_next = GAIN_NOMINAL;
        GC_HIGH_A, GC_HIGH_B:       gain_next = GAIN_HIGH;
        default:                    gain_next = GAIN_REDUCED;
      endcase
    end
  end

  // Full-scale mute state machine
  dogzfm_fs_state_t fs_state_reg;
  dogzfm_fs_state_t fs_state_next;
  logic             req_reg;
  logic             req_next;
  logic             fs_any;
  logic             fs_normal_sig;
  logic             rapid_next;

  assign fs_any        = stream_mode && (fs_hit_l || fs_hit_r);
  assign fs_normal_sig = !fs_any;

  always_comb
  begin
    fs_state_next = fs_state_reg;
    req_next      = req_reg;
    rapid_next    = stream_bypass_select;
    case (fs_state_reg)
      FS_NORMAL:
      begin
        if (fullscale_mute_enable && fs_any)
          fs_state_next = FS_MUTED;
      end
      FS_MUTED:
      begin
        if (!fullscale_mute_enable)
          fs_state_next = FS_NORMAL;
        else if (fs_normal_sig && !fullscale_recovery_mode)
          fs_state_next = FS_NORMAL;
        else if (fs_normal_sig && req_reg)
        begin
          fs_state_next = FS_NORMAL;
          req_next      = 1'b0;
        end
        else
          fs_state_next = FS_MUTED;
      end
      default:
        fs_state_next = FS_NORMAL;
    endcase
    // Software write wins over the self-clear
    if (recovery_request_write)
      req_next = recovery_request_wdata;
  end

  // Status register read
  logic [7:0] rdata_next;

  always_comb
  begin
    rdata_next = UNMAPPED_READ_VALUE;
    if (reg_addr == FULLSCALE_STATUS_OFFSET)
    begin
      rdata_next               = FULLSCALE_STATUS_RESET;
      rdata_next[FS_LEFT_BIT]  = fs_hit_l;
      rdata_next[FS_RIGHT_BIT] = fs_hit_r;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      release_reg                <= '0;
      fs_state_reg               <= FS_NORMAL;
      req_reg                    <= 1'b0;
      reg_rdata                  <= FULLSCALE_STATUS_RESET;
      gain_level                 <= GAIN_NOMINAL;
      left_zero_flag             <= 1'b0;
      right_zero_flag            <= 1'b0;
      left_out                   <= '0;
      right_out                  <= '0;
      sample_out_valid           <= 1'b0;
      left_bit_out               <= 1'b0;
      right_bit_out              <= 1'b0;
      stream_out_valid           <= 1'b0;
      fullscale_mute             <= 1'b0;
      fullscale_mute_rapid       <= 1'b0;
      mute_transition_sel        <= TRANSITION_TIME_RESET;
      fullscale_recovery_request <= 1'b0;
    end
    else
    begin
      release_reg                <= release_next;
      fs_state_reg               <= fs_state_next;
      req_reg                    <= req_next;
      reg_rdata                  <= rdata_next;
      gain_level                 <= gain_next;
      left_zero_flag             <= zl_next;
      right_zero_flag            <= zr_next;
      sample_out_valid           <= sample_tick;
      stream_out_valid           <= fs_tick;
      if (sample_tick)
      begin
        left_out  <= route.out_l;
        right_out <= route.out_r;
      end
      if (fs_tick)
      begin
        left_bit_out  <= sbit_l;
        right_bit_out <= sbit_r;
      end
      fullscale_mute             <= (fs_state_next == FS_MUTED);
      fullscale_mute_rapid       <= rapid_next;
      mute_transition_sel        <= transition_time_sel;
      fullscale_recovery_request <= req_next;
    end
  end

endmodule

// file: dogzfm_chk.sv
/*
  Concurrent checks on the output control block's ports.
  Assumes one clock domain and a synchronous active-high reset; bound to dogzfm_top.
*/
`timescale 1ns/100ps
module dogzfm_chk
  import dogzfm_pkg::*;
#(
  parameter int W = 32
)
(
  input wire logic         clock,
  input wire logic         reset,
  input wire logic         soft_run,
  input wire logic         pin_control,
  input wire logic         stream_mode,
  input wire logic         stream_bypass_select,
  input wire logic [2:0]   gain_code,
  input wire logic         zero_flag_polarity,
  input wire logic         zero_detect_enable,
  input wire logic         right_invert_pin,
  input wire logic         fullscale_mute_enable,
  input wire logic         fullscale_recovery_mode,
  input wire logic         recovery_request_write,
  input wire logic [2:0]   transition_time_sel,
  input wire logic         sample_tick,
  input wire logic [W-1:0] left_sample,
  input wire logic [W-1:0] right_sample,
  input wire logic [7:0]   reg_addr,
  input wire logic [7:0]   reg_rdata,
  input wire logic [1:0]   gain_level,
  input wire logic         left_zero_flag,
  input wire logic         right_zero_flag,
  input wire logic [W-1:0] left_out,
  input wire logic [W-1:0] right_out,
  input wire logic         sample_out_valid,
  input wire logic         fullscale_mute,
  input wire logic         fullscale_mute_rapid,
  input wire logic [2:0]   mute_transition_sel,
  input wire logic         fullscale_recovery_request
);
  logic [1:0] live_reg;
  logic [1:0] live_next;
  logic [2:0] run_reg;
  logic [2:0] run_next;
  logic       live;

  // Settle guard after reset, and ticks seen since the run bit rose
  always_comb
  begin
    live_next = {live_reg[0], 1'b1};
    run_next  = run_reg;
    if (!soft_run)
      run_next = 3'h0;
    else if (sample_tick && run_reg != 3'h7)
      run_next = run_reg + 3'h1;
    if (reset)
    begin
      live_next = 2'h0;
      run_next  = 3'h0;
    end
  end

  always_ff @(posedge clock)
  begin
    live_reg <= live_next;
    run_reg  <= run_next;
  end

  assign live = live_reg[1];

  function automatic logic [1:0] gain_of(input logic [2:0] g);
    return (g == GC_NOMINAL_A || g == GC_NOMINAL_B) ? GAIN_NOMINAL :
           (g == GC_HIGH_A || g == GC_HIGH_B) ? GAIN_HIGH : GAIN_REDUCED;
  endfunction

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_detect_on;
    live && zero_detect_enable && !(stream_mode && stream_bypass_select);
  endsequence

  sequence s_muted_idle;
    live && fullscale_mute && fullscale_mute_enable && fullscale_recovery_mode &&
      !fullscale_recovery_request && !recovery_request_write;
  endsequence

  a_gain_decode:
    assert property (live && !pin_control && !stream_mode |=> gain_level == gain_of($past(gain_code)))
    else $error("gain level does not follow gain code");
  a_pin_route:
    assert property (live && pin_control && !stream_mode && sample_tick && !right_invert_pin |=>
      sample_out_valid && left_out == $past(left_sample) && right_out == $past(right_sample))
    else $error("pin control routing is not straight");
  a_zero_off:
    assert property (live && !zero_detect_enable |=>
      {left_zero_flag, right_zero_flag} == {2{$past(zero_flag_polarity)}})
    else $error("zero flags active while detection is off");
  a_bypass_quiet:
    assert property (live && stream_mode && stream_bypass_select |=>
      {left_zero_flag, right_zero_flag} == {2{$past(zero_flag_polarity)}})
    else $error("zero flags active on bypass path");
  a_run_hold:
    assert property (s_detect_on ##0 !soft_run |=>
      {left_zero_flag, right_zero_flag} == {2{!$past(zero_flag_polarity)}})
    else $error("zero flags not held while run bit is low");
  a_zero_clear:
    assert property (s_detect_on ##0 (soft_run && run_reg == 3'h7 && !zero_flag_polarity && sample_tick &&
      left_sample != '0) |=> ##[0:1] !left_zero_flag)
    else $error("left zero flag stays up after nonzero sample");
  a_mute_off:
    assert property (live && !fullscale_mute_enable |=> !fullscale_mute)
    else $error("muted with full-scale mute disabled");
  a_mute_style:
    assert property (live |=> fullscale_mute_rapid == $past(stream_bypass_select) &&
      mute_transition_sel == $past(transition_time_sel))
    else $error("mute method or transition time wrong");
  a_hold_mute:
    assert property (s_muted_idle |=> fullscale_mute)
    else $error("left mute without recovery request");
  a_status_map:
    assert property (live |=> ($past(reg_addr) == FULLSCALE_STATUS_OFFSET) ? reg_rdata[7:2] == 6'h0 :
      reg_rdata == UNMAPPED_READ_VALUE)
    else $error("status read returns wrong pattern");
endmodule

bind dogzfm_top dogzfm_chk #(.W(W)) i_chk (.*);

// file: dogzfm_source.sv
/*
  Audio source model: sample words and stream bits with one-cycle ticks.
  Assumes callers run at the falling edge of the shared clock.
*/
`timescale 1ns/100ps
module dogzfm_source
  import dogzfm_pkg::*;
#(
  parameter int W = 32
)
(
  input  wire logic    clock,
  output logic         sample_tick = 1'b0,
  output logic [W-1:0] left_sample = '0,
  output logic [W-1:0] right_sample = '0,
  output logic         stream_tick = 1'b0,
  output logic         left_bit = 1'b0,
  output logic         right_bit = 1'b0
);
  // Between ticks the lines carry the inverse, so a stale read shows up
  task automatic send_frame(input logic [W-1:0] l, input logic [W-1:0] r, input int gap);
    @(negedge clock);
    sample_tick  = 1'b1;
    left_sample  = l;
    right_sample = r;
    @(negedge clock);
    sample_tick  = 1'b0;
    left_sample  = ~l;
    right_sample = ~r;
    repeat (gap) @(negedge clock);
  endtask

  task automatic send_bit(input logic l, input logic r);
    @(negedge clock);
    stream_tick = 1'b1;
    left_bit    = l;
    right_bit   = r;
    @(negedge clock);
    stream_tick = 1'b0;
    left_bit    = ~l;
    right_bit   = ~r;
  endtask
endmodule

// file: dogzfm_bench.sv
/*
  Self-checking bench for the converter output control block.
  Assumes dogzfm_chk is bound to the design and dogzfm_source feeds it.
*/
`timescale 1ns/100ps
module dogzfm_bench
  import dogzfm_pkg::*;
;
  localparam int W  = 32;
  localparam int ZF = 16;
  localparam int FB = 16;
  logic clock = 0, reset = 1, soft_run = 0, pin_control = 0, stream_mode = 0, stream_bypass_select = 0;
  logic gain_pin = 0, zero_flag_polarity = 0, zero_flag_combined = 0, zero_detect_enable = 0;
  logic channel_swap = 0, mono = 0, left_invert = 0, right_invert = 0, right_invert_pin = 0;
  logic fullscale_mute_enable = 0, fullscale_recovery_mode = 0, recovery_request_write = 0;
  logic recovery_request_wdata = 0, lb = 1, rb = 0;
  logic [2:0] gain_code = 3'h0, transition_time_sel = 3'h0, mute_transition_sel;
  logic [7:0] reg_addr = 8'h00, reg_rdata;
  logic [1:0] gain_level;
  logic sample_tick, stream_tick, left_bit, right_bit, left_zero_flag, right_zero_flag, sample_out_valid;
  logic left_bit_out, right_bit_out, stream_out_valid, fullscale_mute, fullscale_mute_rapid;
  logic fullscale_recovery_request;
  logic [W-1:0] left_sample, right_sample, left_out, right_out;
  int n_mismatch = 0;
  int n_checks = 0;

  always #10 clock = ~clock;

  dogzfm_source #(.W(W)) i_src (.*);

  dogzfm_top #(.W(W), .ZERO_FRAMES(ZF), .FULLSCALE_BITS(FB)) i_dut (.*);

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic chk_word(input logic [W-1:0] got, input logic [W-1:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_pair(input logic [1:0] got, input logic [1:0] exp, input string what);
    chk_word(W'(got), W'(exp), what);
  endtask

  task automatic frames(input int n, input logic [W-1:0] l, input logic [W-1:0] r);
    repeat (n) i_src.send_frame(l, r, 1);
  endtask

  task automatic bits(input int n, input logic hold);
    repeat (n)
    begin
      lb = hold ? lb : ~lb;
      rb = ~rb;
      i_src.send_bit(lb, rb);
      chk_word(W'({stream_out_valid, left_bit_out, right_bit_out}), W'({1'b1, lb, rb}), "bits");
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
    reg_addr = a;
    cyc(1);
    chk_word(W'(reg_rdata), W'(e), what);
  endtask

  task automatic wait_mute(input logic v, input string what);
    for (int i = 0; i < 8 && fullscale_mute !== v; i++) cyc(1);
    chk_pair({1'b0, fullscale_mute}, {1'b0, v}, what);
    if (fullscale_mute !== v)
      end_of_test;
  endtask

  task automatic set_mute(input logic en);
    soft_run = 0;
    cyc(1);
    fullscale_mute_enable = en;
    cyc(1);
    soft_run = 1;
  endtask

  task automatic t_gain;
    for (int g = 0; g < 8; g++)
    begin
      gain_code = g[2:0];
      cyc(2);
      chk_pair(gain_level, (g < 2) ? GAIN_NOMINAL : (g == 4 || g == 5) ? GAIN_HIGH : GAIN_REDUCED, "code");
    end
    pin_control = 1;
    for (int p = 0; p < 2; p++)
    begin
      gain_pin = p[0];
      cyc(2);
      chk_pair(gain_level, p ? GAIN_HIGH : GAIN_NOMINAL, "gain pin");
    end
    pin_control = 0;
  endtask

  task automatic zf(input int n, input logic [1:0] e, input string what);
    cyc(n);
    chk_pair({left_zero_flag, right_zero_flag}, e, what);
  endtask

  task automatic t_zero;
    {zero_detect_enable, soft_run} = 2'b10;
    zf(2, 2'b11, "run low");
    soft_run = 1;
    frames(3, 1, 1);
    zf(0, 2'b11, "early release");
    frames(2, 1, 1);
    zf(1, 2'b00, "late release");
    frames(ZF - 1, 0, 1);
    frames(1, 5, 1);
    frames(ZF - 1, 0, 1);
    zf(2, 2'b00, "broken run");
    frames(1, 0, 1);
    zf(2, 2'b10, "zero run");
    frames(1, 5, 1);
    zf(1, 2'b00, "nonzero");
    frames(ZF, 0, 1);
    zero_flag_polarity = 1;
    zf(2, 2'b01, "inverted");
    {zero_flag_polarity, zero_flag_combined} = 2'b01;
    frames(1, 0, 1);
    zf(2, 2'b00, "one side");
    frames(ZF + 1, 0, 0);
    zf(2, 2'b11, "both zero");
    {zero_detect_enable, zero_flag_combined} = 2'b00;
    zf(2, 2'b00, "off");
    zero_flag_polarity = 1;
    zf(2, 2'b11, "off inverted");
    {zero_detect_enable, zero_flag_polarity, stream_mode, stream_bypass_select} = 4'b1011;
    zf(2, 2'b00, "bypass");
    {stream_mode, stream_bypass_select} = 2'b00;
  endtask

  task automatic t_route;
    logic [W-1:0] a, b, sl, sr;
    a = 32'h0000_1234;
    b = 32'h0abc_0000;
    for (int k = 0; k < 16; k++)
    begin
      {mono, channel_swap, left_invert, right_invert} = k[3:0];
      i_src.send_frame(a, b, 0);
      sl = channel_swap ? b : a;
      sr = mono ? sl : (channel_swap ? a : b);
      chk_word(left_out, left_invert ? -sl : sl, "left route");
      chk_word(right_out, right_invert ? -sr : sr, "right route");
      chk_pair({1'b0, sample_out_valid}, 2'b01, "valid");
    end
    pin_control = 1;
    for (int p = 0; p < 2; p++)
    begin
      right_invert_pin = p[0];
      i_src.send_frame(a, b, 0);
      chk_word(left_out, a, "pin left");
      chk_word(right_out, p ? -b : b, "pin right");
    end
    {pin_control, mono, channel_swap, left_invert, right_invert} = '0;
  endtask

  task automatic t_fs;
    {stream_mode, transition_time_sel} = 4'hd;
    gain_code = 3'h4;
    set_mute(0);
    chk_pair(gain_level, GAIN_HIGH, "stream gain");
    bits(FB + 2, 1);
    rd(FULLSCALE_STATUS_OFFSET, 8'h01, "status");
    rd(8'h07, UNMAPPED_READ_VALUE, "unmapped");
    chk_pair({1'b0, fullscale_mute}, 2'b00, "no mute");
    bits(2, 0);
    rd(FULLSCALE_STATUS_OFFSET, 8'h00, "status clear");
    set_mute(1);
    bits(FB + 2, 1);
    wait_mute(1, "mute");
    bits(2, 0);
    wait_mute(0, "auto return");
    fullscale_recovery_mode = 1;
    bits(FB + 2, 1);
    wait_mute(1, "mute again");
    bits(4, 0);
    cyc(4);
    chk_pair({1'b0, fullscale_mute}, 2'b01, "held");
    {recovery_request_write, recovery_request_wdata} = 2'b11;
    cyc(1);
    {recovery_request_write, recovery_request_wdata} = 2'b00;
    wait_mute(0, "requested return");
    cyc(1);
    chk_pair({1'b0, fullscale_recovery_request}, 2'b00, "request clear");
    set_mute(0);
    stream_mode = 0;
  endtask

  initial
  begin
    repeat (100000) @(posedge clock);
    n_mismatch++;
    end_of_test;
  end

  initial
  begin
    cyc(2);
    reset = 0;
    cyc(2);
    soft_run = 1;
    t_gain;
    t_zero;
    t_route;
    t_fs;
    end_of_test;
  end
endmodule
